// *** hdl/cet_pkg.sv ***
// constants, register map and types shared by the event timer files
package cet_pkg;
   // ===================================================================
   // timing
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned TICK_PERIOD_NS = 1000000000;
   localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned SEC_PER_HOUR   = 3600;
   localparam int unsigned SEC_PER_MIN    = 60;
   localparam int unsigned SEC_PER_DAY    = 86400;
   localparam int unsigned DAYS_PER_WEEK  = 7;
   localparam int unsigned CNT_W          = 17;

   // ===================================================================
   // register offsets (byte addresses)
   localparam logic [5:0] OFF_CTRL  = 6'h00;
   localparam logic [5:0] OFF_MAIN  = 6'h04;
   localparam logic [5:0] OFF_LEAD  = 6'h08;
   localparam logic [5:0] OFF_AFTER = 6'h0c;
   localparam logic [5:0] OFF_ON    = 6'h10;
   localparam logic [5:0] OFF_OFF   = 6'h14;
   localparam logic [5:0] OFF_CLOCK = 6'h18;
   localparam logic [5:0] OFF_STAT  = 6'h1c;
   localparam logic [5:0] OFF_COUNT = 6'h20;

   // ===================================================================
   // field positions
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_POL_BIT  = 2;
   localparam int unsigned CTRL_RESP_LSB = 3;
   localparam int unsigned CTRL_DAYS_LSB = 8;
   localparam int unsigned MAIN_SS_LSB   = 0;
   localparam int unsigned MAIN_MM_LSB   = 8;
   localparam int unsigned MAIN_HH_LSB   = 16;
   localparam int unsigned CLOCK_DAY_LSB = 24;

   // ===================================================================
   // reset values
   localparam logic [31:0] CTRL_RST  = 32'h00007f04;
   localparam logic [31:0] MAIN_RST  = 32'h00000000;
   localparam logic [13:0] LEAD_RST  = 14'h0000;
   localparam logic [15:0] AFTER_RST = 16'h0000;
   localparam logic [16:0] TOD_RST   = 17'h00000;

   // ===================================================================
   // enumerations
   typedef enum logic [1:0] {MODE_INACTIVE, MODE_TIMING, MODE_WEEKLY} cet_mode_t;
   typedef enum logic [1:0] {RESP_STOP, RESP_CONTINUE, RESP_RESTART} cet_resp_t;
   typedef enum logic [2:0] {PH_IDLE, PH_LEAD, PH_MAIN, PH_AFTER, PH_DONE} cet_phase_t;
endpackage

// *** hdl/cet_tick.sv ***
// one-cycle tick every DIV clock cycles
`timescale 1ns/1ns
module cet_tick #(
   parameter int unsigned DIV = cet_pkg::TICK_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst,
   output logic      tick
);
   localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   logic [W-1:0] div_r;
   logic         tick_r;

   // ===================================================================
   // prescaler: free running so that the seconds stay in phase
   always_ff @(posedge clk) begin
      if (rst) begin
         div_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         div_r  <= (div_r == LAST) ? '0 : div_r + 1'b1;
         tick_r <= (div_r == LAST);
      end
   end

   assign tick = tick_r;
endmodule

// *** hdl/cet_timer.sv ***
// event timer core with Avalon-MM register slave
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ns

// Operation
// RL1: mode selects inactive, timing element or weekly switch, and only that mode drives the output.
// RL2: on return of supply the timer stops, continues, or restarts its sequence as configured.
// RL3: the main interval in hh:mm:ss is counted and the output asserts only after it elapses.
// RL4: a lead delay of 0 to 9999 seconds precedes the main interval after a start.
// RL5: an after-run interval of up to 9999 seconds follows the main interval as the last phase.
// RL6: an after-run setting of minus one makes the after-run phase endless.
// RL7: quit during a positive after-run phase returns the timer to idle.
// RL8: a rising start input begins a sequence with the lead delay.
// RL9: start is ignored until lead delay and main interval have both elapsed.
// RL10: polarity high passes the timer output, polarity low inverts it; the code applies polarity in timing mode only, not in weekly mode.
// RL11: an active stop input returns the timer to idle from any phase.
// RL12: restart during lead or main resets and begins a fresh sequence at once.
// RL13: an active hold input freezes counting and phase until released; the code still obeys stop, supply, restart, quit and start during hold.
// RL14: counters advance only on a one-second tick and synchronous reset idles the timer.
// RL15: weekly mode sets the output at the switch-on time and clears it at the switch-off time.
module cet_timer #(
   parameter int unsigned TICK_DIV = cet_pkg::TICK_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [5:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [3:0]  byteenable,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   input  wire logic        start_in,
   input  wire logic        stop_in,
   input  wire logic        hold_in,
   input  wire logic        restart_in,
   input  wire logic        quit_in,
   input  wire logic        power_lost_in,
   output logic             timer_out
);
   localparam logic [16:0] DAY_LAST = 17'(cet_pkg::SEC_PER_DAY - 1);
   localparam logic [2:0]  WDAY_LAST = 3'(cet_pkg::DAYS_PER_WEEK - 1);

   // ===================================================================
   // declarations
   logic [31:0] ctrl_r, main_r;
   logic [13:0] lead_r;
   logic [15:0] after_r;
   logic [16:0] on_r, off_r, tod_r;
   logic [2:0]  wday_r;
   logic [5:0]  sync1_r, sync2_r;
   logic        start_q_r, pwr_q_r;
   logic        wait_r, out_r, weekly_r;
   logic [31:0] rdata_r;
   cet_pkg::cet_phase_t phase_r, phase_nxt;
   logic [16:0] cnt_r, cnt_nxt;
   logic        tick;

   // ===================================================================
   // pin synchronisers: first stage feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {power_lost_in, quit_in, restart_in, hold_in, stop_in, start_in};
         sync2_r <= sync1_r;
      end
   end

   // edge memories for start and supply return
   always_ff @(posedge clk) begin
      if (rst) begin
         start_q_r <= 1'b0;
         pwr_q_r   <= 1'b0;
      end else begin
         start_q_r <= sync2_r[0];
         pwr_q_r   <= sync2_r[5];
      end
   end

   wire start_s     = sync2_r[0];
   wire stop_s      = sync2_r[1];
   wire hold_s      = sync2_r[2];
   wire restart_s   = sync2_r[3];
   wire quit_s      = sync2_r[4];
   wire pwr_s       = sync2_r[5];
   wire start_rise  = start_s & ~start_q_r;
   wire pwr_return  = pwr_q_r & ~pwr_s;

   // ===================================================================
   // one-second time base
   cet_tick #(.DIV(TICK_DIV)) u_tick (
      .clk  (clk),
      .rst  (rst),
      .tick (tick)
   );

   // ===================================================================
   // configuration decode
   wire cet_pkg::cet_mode_t mode_w = cet_pkg::cet_mode_t'(ctrl_r[cet_pkg::CTRL_MODE_LSB +: 2]);
   wire cet_pkg::cet_resp_t resp_w = cet_pkg::cet_resp_t'(ctrl_r[cet_pkg::CTRL_RESP_LSB +: 2]);
   wire       pol_w    = ctrl_r[cet_pkg::CTRL_POL_BIT];
   wire [6:0] days_w   = ctrl_r[cet_pkg::CTRL_DAYS_LSB +: 7];
   wire       timing_w = (mode_w == cet_pkg::MODE_TIMING);
   wire [16:0] main_secs = 17'(main_r[cet_pkg::MAIN_HH_LSB +: 5]) * 17'(cet_pkg::SEC_PER_HOUR)
                         + 17'(main_r[cet_pkg::MAIN_MM_LSB +: 6]) * 17'(cet_pkg::SEC_PER_MIN)
                         + 17'(main_r[cet_pkg::MAIN_SS_LSB +: 6]);
   wire [16:0] lead_secs  = {3'h0, lead_r};
   wire [16:0] after_secs = {2'h0, after_r[14:0]};
   wire        after_inf  = (after_r == 16'hffff);               // see RL6
   wire        after_pos  = ~after_r[15] & (after_r != 16'h0000);
   wire        run_w      = ~hold_s & ~pwr_s;                      // see RL13
   wire        can_start  = (phase_r == cet_pkg::PH_IDLE) | (phase_r == cet_pkg::PH_AFTER)
                          | (phase_r == cet_pkg::PH_DONE);          // see RL9
   wire        in_seq     = (phase_r == cet_pkg::PH_LEAD) | (phase_r == cet_pkg::PH_MAIN);
   wire        raw_w      = (phase_r == cet_pkg::PH_AFTER) | (phase_r == cet_pkg::PH_DONE);

   // ===================================================================
   // sequence control; priority runs stop, supply, restart, quit, start, count
   always_comb begin
      phase_nxt = phase_r;
      cnt_nxt   = cnt_r;
      if (!timing_w || stop_s) begin                             // see RL1 see RL11
         phase_nxt = cet_pkg::PH_IDLE;
         cnt_nxt   = '0;
      end else if (pwr_return && resp_w == cet_pkg::RESP_STOP) begin  // see RL2
         phase_nxt = cet_pkg::PH_IDLE;
         cnt_nxt   = '0;
      end else if (pwr_return && resp_w == cet_pkg::RESP_RESTART) begin  // see RL2
         phase_nxt = cet_pkg::PH_LEAD;
         cnt_nxt   = '0;
      end else if (restart_s && in_seq) begin                    // see RL12
         phase_nxt = cet_pkg::PH_LEAD;
         cnt_nxt   = '0;
      end else if (quit_s && after_pos && phase_r == cet_pkg::PH_AFTER) begin  // see RL7
         phase_nxt = cet_pkg::PH_IDLE;
         cnt_nxt   = '0;
      end else if (start_rise && can_start) begin                // see RL8 see RL9
         phase_nxt = cet_pkg::PH_LEAD;
         cnt_nxt   = '0;
      end else if (run_w) begin
         case (phase_r)
            cet_pkg::PH_LEAD: begin
               if (cnt_r >= lead_secs) begin                     // see RL4
                  phase_nxt = cet_pkg::PH_MAIN;
                  cnt_nxt   = '0;
               end else if (tick) begin                          // see RL14
                  cnt_nxt = cnt_r + 17'h00001;
               end
            end
            cet_pkg::PH_MAIN: begin
               if (cnt_r >= main_secs) begin                     // see RL3
                  phase_nxt = (after_inf || after_pos) ? cet_pkg::PH_AFTER : cet_pkg::PH_DONE;
                  cnt_nxt   = '0;
               end else if (tick) begin
                  cnt_nxt = cnt_r + 17'h00001;
               end
            end
            cet_pkg::PH_AFTER: begin
               if (after_pos && cnt_r >= after_secs) begin       // see RL5
                  phase_nxt = cet_pkg::PH_IDLE;
                  cnt_nxt   = '0;
               end else if (tick && !after_inf) begin            // endless phase never counts
                  cnt_nxt = cnt_r + 17'h00001;
               end
            end
            default: begin
               phase_nxt = phase_r;
            end
         endcase
      end
   end

   // phase and count registers; continue-after-supply keeps them as they were
   always_ff @(posedge clk) begin
      if (rst) begin                                             // see RL14
         phase_r <= cet_pkg::PH_IDLE;
         cnt_r   <= '0;
      end else begin
         phase_r <= phase_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // ===================================================================
   // weekly time of day and switch
   wire        tod_wrap = (tod_r == DAY_LAST);
   wire        day_on   = days_w[wday_r];
   wire        clk_wr   = write & ~wait_r & (address == cet_pkg::OFF_CLOCK);

   always_ff @(posedge clk) begin
      if (rst) begin
         tod_r  <= cet_pkg::TOD_RST;
         wday_r <= 3'h0;
      end else if (clk_wr) begin
         tod_r  <= writedata[16:0];
         wday_r <= writedata[cet_pkg::CLOCK_DAY_LSB +: 3];
      end else if (tick) begin
         tod_r  <= tod_wrap ? 17'h00000 : tod_r + 17'h00001;
         wday_r <= !tod_wrap ? wday_r : (wday_r >= WDAY_LAST) ? 3'h0 : wday_r + 3'h1;
      end
   end

   // switch-on beats switch-off when both fall on the same second
   always_ff @(posedge clk) begin
      if (rst) begin
         weekly_r <= 1'b0;
      end else if (tick && day_on && tod_r == on_r) begin        // see RL15
         weekly_r <= 1'b1;
      end else if (tick && day_on && tod_r == off_r) begin       // see RL15
         weekly_r <= 1'b0;
      end
   end

   // ===================================================================
   // output select and polarity
   wire out_nxt = timing_w ? (raw_w ^ ~pol_w)                    // see RL10
                : (mode_w == cet_pkg::MODE_WEEKLY) ? weekly_r : 1'b0;  // see RL1

   always_ff @(posedge clk) begin
      if (rst) begin
         out_r <= 1'b0;
      end else begin
         out_r <= out_nxt;
      end
   end

   // ===================================================================
   // Avalon slave: one wait cycle, write lands on the edge waitrequest is low
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      merge = (old & ~m) | (nw & m);
   endfunction

   wire        wr_go = write & ~wait_r;
   // narrow registers merge as a full word, then keep only their own bits
   wire [31:0] lead_m  = merge({18'h0, lead_r}, writedata, byteenable);
   wire [31:0] after_m = merge({16'h0, after_r}, writedata, byteenable);
   wire [31:0] on_m    = merge({15'h0, on_r}, writedata, byteenable);
   wire [31:0] off_m   = merge({15'h0, off_r}, writedata, byteenable);
   wire [31:0] stat_w = {26'h0, hold_s, pwr_s, out_r, phase_r};
   wire [31:0] rdata_w =
        (address == cet_pkg::OFF_CTRL)  ? ctrl_r :
        (address == cet_pkg::OFF_MAIN)  ? main_r :
        (address == cet_pkg::OFF_LEAD)  ? {18'h0, lead_r} :
        (address == cet_pkg::OFF_AFTER) ? {16'h0, after_r} :
        (address == cet_pkg::OFF_ON)    ? {15'h0, on_r} :
        (address == cet_pkg::OFF_OFF)   ? {15'h0, off_r} :
        (address == cet_pkg::OFF_CLOCK) ? {5'h0, wday_r, 7'h0, tod_r} :
        (address == cet_pkg::OFF_STAT)  ? stat_w :
        (address == cet_pkg::OFF_COUNT) ? {15'h0, cnt_r} : 32'h0;

   // handshake and read capture
   always_ff @(posedge clk) begin
      if (rst) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0;
      end else begin
         wait_r  <= ~((read | write) & wait_r);
         rdata_r <= (read & wait_r) ? rdata_w : rdata_r;
      end
   end

   // writable registers; unmapped writes are dropped
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r  <= cet_pkg::CTRL_RST;
         main_r  <= cet_pkg::MAIN_RST;
         lead_r  <= cet_pkg::LEAD_RST;
         after_r <= cet_pkg::AFTER_RST;
         on_r    <= cet_pkg::TOD_RST;
         off_r   <= cet_pkg::TOD_RST;
      end else if (wr_go) begin
         if (address == cet_pkg::OFF_CTRL)
            ctrl_r <= merge(ctrl_r, writedata, byteenable) & 32'h00007f1f;
         if (address == cet_pkg::OFF_MAIN)
            main_r <= merge(main_r, writedata, byteenable) & 32'h001f3f3f;
         if (address == cet_pkg::OFF_LEAD)
            lead_r <= lead_m[13:0];
         if (address == cet_pkg::OFF_AFTER)
            after_r <= after_m[15:0];
         if (address == cet_pkg::OFF_ON)
            on_r <= on_m[16:0];
         if (address == cet_pkg::OFF_OFF)
            off_r <= off_m[16:0];
      end
   end

   assign readdata    = rdata_r;
   assign waitrequest = wait_r;
   assign timer_out   = out_r;

   // ===================================================================
   // assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   wire ok_w = timing_w & ~stop_s & ~pwr_return;

   inactive_output_a: assert property (   // see RL1
      (mode_w == cet_pkg::MODE_INACTIVE) |=> !timer_out)
      else $error("inactive mode drives output");

   supply_stop_a: assert property (   // see RL2
      (timing_w && !stop_s && pwr_return && resp_w == cet_pkg::RESP_STOP)
      |=> phase_r == cet_pkg::PH_IDLE)
      else $error("supply stop did not idle");

   main_expire_a: assert property (   // see RL3
      (ok_w && !restart_s && run_w && phase_r == cet_pkg::PH_MAIN && cnt_r >= main_secs)
      |=> (phase_r == cet_pkg::PH_AFTER || phase_r == cet_pkg::PH_DONE) && cnt_r == 17'h0)
      else $error("main interval did not expire");

   lead_count_a: assert property (   // see RL4 see RL14
      (ok_w && !restart_s && run_w && tick && phase_r == cet_pkg::PH_LEAD && cnt_r < lead_secs)
      |=> cnt_r == $past(cnt_r) + 17'h00001)
      else $error("lead count did not advance on tick");

   endless_after_a: assert property (   // see RL6
      (ok_w && after_inf && !start_rise && phase_r == cet_pkg::PH_AFTER)
      |=> phase_r == cet_pkg::PH_AFTER)
      else $error("endless after-run ended");

   quit_reset_a: assert property (   // see RL7
      (ok_w && quit_s && after_pos && phase_r == cet_pkg::PH_AFTER) |=> phase_r == cet_pkg::PH_IDLE)
      else $error("quit ignored in after-run");

   start_begin_a: assert property (   // see RL8
      (ok_w && start_rise && phase_r == cet_pkg::PH_IDLE) |=> phase_r == cet_pkg::PH_LEAD)
      else $error("start did not begin lead");

   no_retrigger_a: assert property (   // see RL9
      (ok_w && !restart_s && phase_r == cet_pkg::PH_MAIN) |=> phase_r != cet_pkg::PH_LEAD)
      else $error("start retriggered during main");

   polarity_out_a: assert property (   // see RL10
      (timing_w && raw_w) |=> timer_out == $past(pol_w))
      else $error("polarity not applied");

   stop_idle_a: assert property (   // see RL11
      stop_s |=> phase_r == cet_pkg::PH_IDLE && cnt_r == 17'h0)
      else $error("stop did not idle");

   restart_fresh_a: assert property (   // see RL12
      (ok_w && restart_s && in_seq) |=> phase_r == cet_pkg::PH_LEAD && cnt_r == 17'h0)
      else $error("restart did not reload");

   hold_freeze_a: assert property (   // see RL13
      (ok_w && hold_s && !restart_s && !start_rise && phase_r != cet_pkg::PH_AFTER)
      |=> $stable(cnt_r) && $stable(phase_r))
      else $error("hold did not freeze");

   weekly_on_a: assert property (   // see RL15
      (mode_w == cet_pkg::MODE_WEEKLY && tick && day_on && tod_r == on_r && !clk_wr)
      ##1 (mode_w == cet_pkg::MODE_WEEKLY) |=> timer_out)
      else $error("weekly switch-on missed");
endmodule

// *** tb/cet_pins_model.sv ***
// partner model: the binary signal sources feeding the timer control pins
`timescale 1ns/1ns
module cet_pins_model (
   input  wire logic clk,
   output logic      start_in,
   output logic      stop_in,
   output logic      hold_in,
   output logic      restart_in,
   output logic      quit_in,
   output logic      power_lost_in
);
   // ===================================================================
   // pin levels
   // levels only move right after a rising edge, never mid-cycle
   logic [5:0] pins_r = 6'h00;
   assign {power_lost_in, quit_in, restart_in, hold_in, stop_in, start_in} = pins_r;

   // set all pin levels at once
   task automatic drive(input logic [5:0] v);
      @(posedge clk);
      pins_r <= v;
   endtask

   // toggle the given pins for three cycles, long enough to clear the synchroniser
   task automatic pulse(input logic [5:0] v);
      drive(pins_r ^ v);
      repeat (3) @(posedge clk);
      pins_r <= pins_r ^ v;
   endtask
endmodule

// *** tb/tb_top.sv ***
// self-checking testbench of the event timer
`timescale 1ns/1ns
module tb_top;
   // ===================================================================
   // signals
   // short tick so whole sequences fit in a few hundred cycles
   localparam int unsigned DIV = 10;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [5:0]  address = 6'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [3:0]  byteenable = 4'h0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        start_in, stop_in, hold_in, restart_in, quit_in, power_lost_in;
   logic        timer_out;
   int          failures = 0;
   int          checks_done = 0;
   logic [3:0]  lanes = 4'hf;

   always #5 clk = ~clk;

   cet_timer #(
      .TICK_DIV      (DIV)
   ) i_cet_timer (
      .clk           (clk),
      .rst           (rst),
      .address       (address),
      .read          (read),
      .write         (write),
      .byteenable    (byteenable),
      .writedata     (writedata),
      .readdata      (readdata),
      .waitrequest   (waitrequest),
      .start_in      (start_in),
      .stop_in       (stop_in),
      .hold_in       (hold_in),
      .restart_in    (restart_in),
      .quit_in       (quit_in),
      .power_lost_in (power_lost_in),
      .timer_out     (timer_out)
   );

   cet_pins_model i_cet_pins_model (
      .clk           (clk),
      .start_in      (start_in),
      .stop_in       (stop_in),
      .hold_in       (hold_in),
      .restart_in    (restart_in),
      .quit_in       (quit_in),
      .power_lost_in (power_lost_in)
   );

   // ===================================================================
   // helpers
   task automatic final_report();
      $display("checks done %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic timeout(input string what);
      failures++;
      $display("ERROR %s expected completion seen timeout", what);
      final_report();
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one avalon access; request held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      @(posedge clk);
      address <= a;
      writedata <= wd;
      byteenable <= lanes;
      write <= wr;
      read <= ~wr;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (waitrequest === 1'b0) break;
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n == 50) timeout("bus");
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      bus(1'b1, a, d, dummy);
   endtask

   task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] exp);
      logic [31:0] d;
      bus(1'b0, a, 32'h0, d);
      chk(what, d, exp);
   endtask

   task automatic chk_ph(input cet_pkg::cet_phase_t p);
      logic [31:0] d;
      bus(1'b0, cet_pkg::OFF_STAT, 32'h0, d);
      chk("phase", {29'h0, d[2:0]}, {29'h0, p});
   endtask

   // polling by register reads, bounded
   task automatic wait_ph(input cet_pkg::cet_phase_t p);
      logic [31:0] d;
      int n;
      for (n = 0; n < 150; n++) begin
         bus(1'b0, cet_pkg::OFF_STAT, 32'h0, d);
         if (d[2:0] === p) break;
      end
      if (n == 150) timeout("phase");
   endtask

   task automatic wait_out(input logic v);
      int n;
      for (n = 0; n < 300; n++) begin
         @(posedge clk);
         if (timer_out === v) break;
      end
      if (n == 300) timeout("timer_out");
   endtask

   task automatic setup(input logic [31:0] ctrl, lead, main, after);
      wr(cet_pkg::OFF_CTRL, ctrl);
      wr(cet_pkg::OFF_LEAD, lead);
      wr(cet_pkg::OFF_MAIN, main);
      wr(cet_pkg::OFF_AFTER, after);
   endtask

   // ===================================================================
   // scenarios
   task automatic t_reset();
      rd_chk("ctrl", cet_pkg::OFF_CTRL, 32'h00007f04);
      rd_chk("main", cet_pkg::OFF_MAIN, 32'h0);
      rd_chk("stat", cet_pkg::OFF_STAT, 32'h0);
      wr(6'h24, 32'hffffffff);
      rd_chk("unmapped", 6'h24, 32'h0);
      // a single lane write must leave the other bytes untouched
      lanes = 4'h1;
      wr(cet_pkg::OFF_LEAD, 32'h00001234);
      lanes = 4'hf;
      rd_chk("lead lanes", cet_pkg::OFF_LEAD, 32'h00000034);
      chk("out", {31'h0, timer_out}, 32'h0);
   endtask

   task automatic t_sequence();
      setup(32'h00007f05, 32'h2, 32'h3, 32'h2);
      i_cet_pins_model.pulse(6'h01);
      wait_ph(cet_pkg::PH_LEAD);
      chk("out", {31'h0, timer_out}, 32'h0);
      wait_ph(cet_pkg::PH_MAIN);
      repeat (15) @(posedge clk);
      chk_ph(cet_pkg::PH_MAIN);
      chk("out", {31'h0, timer_out}, 32'h0);
      wait_ph(cet_pkg::PH_AFTER);
      repeat (2) @(posedge clk);
      chk("out", {31'h0, timer_out}, 32'h1);
      wait_ph(cet_pkg::PH_IDLE);
      repeat (2) @(posedge clk);
      chk("out", {31'h0, timer_out}, 32'h0);
   endtask

   task automatic t_retrigger();
      setup(32'h00007f05, 32'h2, 32'h5, 32'h0);
      i_cet_pins_model.pulse(6'h01);
      wait_ph(cet_pkg::PH_MAIN);
      i_cet_pins_model.pulse(6'h01);
      chk_ph(cet_pkg::PH_MAIN);
      i_cet_pins_model.pulse(6'h08);
      chk_ph(cet_pkg::PH_LEAD);
      wait_ph(cet_pkg::PH_DONE);
      i_cet_pins_model.pulse(6'h01);
      chk_ph(cet_pkg::PH_LEAD);
      i_cet_pins_model.pulse(6'h02);
      chk_ph(cet_pkg::PH_IDLE);
      chk("out", {31'h0, timer_out}, 32'h0);
   endtask

   task automatic t_hold();
      logic [31:0] c1, c2;
      setup(32'h00007f05, 32'h0, 32'h8, 32'h0);
      i_cet_pins_model.pulse(6'h01);
      wait_ph(cet_pkg::PH_MAIN);
      i_cet_pins_model.drive(6'h04);
      repeat (5) @(posedge clk);
      bus(1'b0, cet_pkg::OFF_COUNT, 32'h0, c1);
      repeat (40) @(posedge clk);
      bus(1'b0, cet_pkg::OFF_COUNT, 32'h0, c2);
      chk("count", c2, c1);
      chk_ph(cet_pkg::PH_MAIN);
      i_cet_pins_model.drive(6'h00);
      wait_ph(cet_pkg::PH_DONE);
      i_cet_pins_model.pulse(6'h02);
   endtask

   task automatic t_after_run();
      setup(32'h00007f05, 32'h0, 32'h0, 32'h0000ffff);
      i_cet_pins_model.pulse(6'h01);
      wait_ph(cet_pkg::PH_AFTER);
      i_cet_pins_model.pulse(6'h10);
      repeat (60) @(posedge clk);
      chk_ph(cet_pkg::PH_AFTER);
      i_cet_pins_model.pulse(6'h02);
      wr(cet_pkg::OFF_AFTER, 32'h5);
      i_cet_pins_model.pulse(6'h01);
      wait_ph(cet_pkg::PH_AFTER);
      i_cet_pins_model.pulse(6'h10);
      chk_ph(cet_pkg::PH_IDLE);
   endtask

   task automatic t_polarity();
      setup(32'h00007f01, 32'h0, 32'h0, 32'h0);
      repeat (4) @(posedge clk);
      chk("out", {31'h0, timer_out}, 32'h1);
      i_cet_pins_model.pulse(6'h01);
      wait_ph(cet_pkg::PH_DONE);
      repeat (2) @(posedge clk);
      chk("out", {31'h0, timer_out}, 32'h0);
      i_cet_pins_model.pulse(6'h02);
   endtask

   // the three supply responses, one loop pass each
   task automatic t_power();
      cet_pkg::cet_phase_t exp_ph [3] = '{cet_pkg::PH_IDLE, cet_pkg::PH_MAIN,
                                          cet_pkg::PH_LEAD};
      for (int r = 0; r < 3; r++) begin
         setup(32'h00007f05 | (32'(r) << 3), 32'h3, 32'h9, 32'h0);
         i_cet_pins_model.pulse(6'h01);
         wait_ph(cet_pkg::PH_MAIN);
         i_cet_pins_model.drive(6'h20);
         repeat (20) @(posedge clk);
         i_cet_pins_model.drive(6'h00);
         repeat (6) @(posedge clk);
         chk_ph(exp_ph[r]);
         i_cet_pins_model.pulse(6'h02);
         wait_ph(cet_pkg::PH_IDLE);
      end
   endtask

   task automatic t_modes();
      wr(cet_pkg::OFF_CTRL, 32'h00007f00);
      i_cet_pins_model.pulse(6'h01);
      chk_ph(cet_pkg::PH_IDLE);
      chk("out", {31'h0, timer_out}, 32'h0);
      // off comes first: the switch may already be on from the reset time of day
      wr(cet_pkg::OFF_ON, 32'h8);
      wr(cet_pkg::OFF_OFF, 32'h3);
      wr(cet_pkg::OFF_CTRL, 32'h00007f02);
      wr(cet_pkg::OFF_CLOCK, 32'h0);
      wait_out(1'b0);
      repeat (15) @(posedge clk);
      chk("out", {31'h0, timer_out}, 32'h0);
      wait_out(1'b1);
      repeat (15) @(posedge clk);
      chk("out", {31'h0, timer_out}, 32'h1);
   endtask

   // ===================================================================
   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_sequence();
      t_retrigger();
      t_hold();
      t_after_run();
      t_polarity();
      t_power();
      t_modes();
      final_report();
   end
endmodule
